// file: design/ppr_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ppr_defs.svh"

module ppr_top
    import ppr_pkg::*;
#(
    parameter int NB = `PPR_BANKS,
    parameter int ROWW = `PPR_ROW_W,
    parameter int DQW = `PPR_DQ_W,
    parameter int TMOD_CYC = `PPR_TMOD_CYC,
    parameter bit CAP_HARD = 1'b1,
    parameter bit CAP_SOFT = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    localparam int BKW = $clog2(NB);
    localparam logic [7:0] TMOD = 8'(TMOD_CYC);
    localparam logic [3:0] GROUPS = 4'(NB / 4);

    typedef struct packed {
        ppr_fsm_t fsm;
        logic soft_en;
        logic hard_en;
        logic [1:0] keys;
        logic [7:0] tmod;
        logic hard_mode;
        logic [BKW-1:0] tgt;
        logic [ROWW-1:0] row;
        logic [1:0] beats;
        logic bad;
        logic applied;
        logic noop;
        ppr_bank_t [NB-1:0] bst;
        logic [NB-1:0][ROWW-1:0] brow;
        logic lk_hit;
        logic lk_hard;
        logic [BKW-1:0] lk_idx;
        logic ack;
        logic [31:0] dat;
    } ppr_state_t;

    ppr_state_t q;
    ppr_state_t n;
    logic wr;
    logic rd;
    logic key_ok;
    logic commit;
    logic [11:0] key_exp;
    logic [BKW-1:0] bank_in;
    logic [ROWW-1:0] row_in;

    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        n = q;
        n.ack = 1'b0;
        n.dat = 32'h0000_0000;
        commit = 1'b0;
        // partial-lane writes are dropped so a key never half-lands
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack && (wb_sel_i == 4'hF);
        rd = wb_cyc_i && wb_stb_i && !wb_we_i && !q.ack;
        bank_in = wb_dat_i[`PPR_BANK_LSB +: BKW];
        row_in = wb_dat_i[ROWW-1:0];
        case (q.keys)
            2'h0: key_exp = `PPR_KEY0;
            2'h1: key_exp = `PPR_KEY1;
            2'h2: key_exp = `PPR_KEY2;
            default: key_exp = `PPR_KEY3;
        endcase
        key_ok = (wb_dat_i[11:0] == key_exp) && (wb_dat_i[`PPR_KEY_GRP_LSB +: 4] == 4'h0)
            && (q.tmod >= TMOD);
        if (wb_cyc_i && wb_stb_i && !q.ack) begin
            n.ack = 1'b1;
        end
        if (q.tmod != 8'hFF) begin
            n.tmod = q.tmod + 8'h01;
        end
        if (wr && wb_adr_i == `PPR_OFF_MODE) begin
            n.soft_en = wb_dat_i[`PPR_BIT_SOFT];
            n.hard_en = wb_dat_i[`PPR_BIT_HARD];
        end
        case (q.fsm)
            S_IDLE: begin
                // both enables at once is refused outright
                if (wr && wb_adr_i == `PPR_OFF_MODE && (n.soft_en ^ n.hard_en)) begin
                    n.fsm = S_KEYS;
                    n.keys = 2'h0;
                    n.tmod = TMOD;
                    n.hard_mode = n.hard_en;
                end
            end
            S_KEYS: begin
                if (wr) begin
                    if (wb_adr_i == `PPR_OFF_KEY && key_ok) begin
                        n.keys = q.keys + 2'h1;
                        // accept edge counts as the first cycle of the gap
                        n.tmod = 8'h01;
                        if (q.keys == `PPR_KEYS_LAST) begin
                            n.fsm = S_ARMED;
                        end
                    end else begin
                        n.fsm = S_IDLE;
                        n.noop = 1'b1;
                    end
                end
            end
            S_ARMED: begin
                if (wr && wb_adr_i == `PPR_OFF_TARGET) begin
                    n.tgt = bank_in;
                    n.row = row_in;
                    n.fsm = S_DATA;
                    n.beats = 2'h0;
                    n.bad = 1'b0;
                end
            end
            S_DATA: begin
                if (wr && wb_adr_i == `PPR_OFF_BURST) begin
                    n.bad = q.bad || (wb_dat_i[DQW-1:0] != '0) || (wb_dat_i[16 +: DQW] != '0);
                    n.beats = q.beats + 2'h1;
                    if (q.beats == `PPR_BEATS_LAST) begin
                        n.fsm = S_DONE;
                        commit = !n.bad;
                        n.applied = commit;
                        n.noop = !commit;
                    end
                end else if (wr) begin
                    n.fsm = S_IDLE;
                    n.noop = 1'b1;
                end
            end
            S_DONE: begin
            end
            default: begin
                n.fsm = S_IDLE;
            end
        endcase
        if (q.fsm != S_IDLE && !(n.soft_en ^ n.hard_en)) begin
            n.fsm = S_IDLE;
        end
        if (q.fsm == S_IDLE && n.fsm == S_KEYS) begin
            n.applied = 1'b0;
            n.noop = 1'b0;
        end
        // a stored hard entry is never overwritten by a later repair; only power-on clears it
        if (commit && q.bst[q.tgt] != PPR_HARD) begin
            n.bst[q.tgt] = q.hard_mode ? PPR_HARD : PPR_SOFT;
            n.brow[q.tgt] = q.row;
        end
        if (wr && wb_adr_i == `PPR_OFF_LOOKUP) begin
            n.lk_hit = (q.bst[bank_in] != PPR_NONE) && (q.brow[bank_in] == row_in);
            n.lk_hard = q.bst[bank_in] == PPR_HARD;
            n.lk_idx = bank_in;
        end
        if (rd) begin
            if (wb_adr_i[7:6] == `PPR_OFF_TABLE) begin
                n.dat[ROWW-1:0] = q.brow[wb_adr_i[2 +: BKW]];
                n.dat[29:28] = q.bst[wb_adr_i[2 +: BKW]];
            end else begin
                case (wb_adr_i)
                    `PPR_OFF_MODE: begin
                        n.dat[`PPR_BIT_SOFT] = q.soft_en;
                        n.dat[`PPR_BIT_HARD] = q.hard_en;
                    end
                    `PPR_OFF_KEY: n.dat[1:0] = q.keys;
                    `PPR_OFF_TARGET: begin
                        n.dat[ROWW-1:0] = q.row;
                        n.dat[`PPR_BANK_LSB +: BKW] = q.tgt;
                    end
                    `PPR_OFF_STATUS: begin
                        n.dat[0] = q.fsm != S_IDLE;
                        n.dat[1] = q.applied;
                        n.dat[2] = q.noop;
                        n.dat[7:4] = GROUPS;
                    end
                    `PPR_OFF_READOUT: begin
                        n.dat[`PPR_BIT_CAP_HARD] = CAP_HARD;
                        n.dat[`PPR_BIT_CAP_SOFT] = CAP_SOFT;
                    end
                    `PPR_OFF_LOOKUP: begin
                        n.dat[0] = q.lk_hit;
                        n.dat[1] = q.lk_hard;
                        n.dat[4 +: BKW] = q.lk_idx;
                    end
                    default: n.dat = 32'h0000_0000;
                endcase
            end
        end
        // device reset drops soft entries; only power-on clears hard ones
        if (rst_i || por_i) begin
            n.fsm = S_IDLE;
            n.soft_en = 1'b0;
            n.hard_en = 1'b0;
            n.keys = 2'h0;
            n.tmod = 8'h00;
            n.hard_mode = 1'b0;
            n.tgt = '0;
            n.row = '0;
            n.beats = 2'h0;
            n.bad = 1'b0;
            n.applied = 1'b0;
            n.noop = 1'b0;
            n.lk_hit = 1'b0;
            n.lk_hard = 1'b0;
            n.lk_idx = '0;
            n.ack = 1'b0;
            n.dat = 32'h0000_0000;
            for (int b = 0; b < NB; b++) begin
                if (por_i || q.bst[b] != PPR_HARD) begin
                    n.bst[b] = PPR_NONE;
                    n.brow[b] = '0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        q <= n;
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);

    logic burst_wr;
    assign burst_wr = q.fsm == S_DATA && wr && wb_adr_i == `PPR_OFF_BURST && q.beats == `PPR_BEATS_LAST;

    for (genvar g = 0; g < NB; g++) begin : g_bank
        property p_hard_sticky;
            q.bst[g] == PPR_HARD |=> q.bst[g] == PPR_HARD && $stable(q.brow[g]);
        endproperty
        a_hard_sticky: assert property (p_hard_sticky) else $error("hard repair changed");
        property p_other_bank;
            burst_wr && q.tgt != g |=> $stable(q.bst[g]) && $stable(q.brow[g]);
        endproperty
        a_other_bank: assert property (p_other_bank) else $error("other bank disturbed");
    end

    property p_commit;
        burst_wr && !n.bad && q.bst[q.tgt] != PPR_HARD
            |=> q.bst[$past(q.tgt)] == ($past(q.hard_mode) ? PPR_HARD : PPR_SOFT)
            && q.brow[$past(q.tgt)] == $past(q.row);
    endproperty
    a_commit: assert property (p_commit) else $error("repair not stored");

    property p_dq_high;
        burst_wr && n.bad |=> $stable(q.bst) && q.noop && !q.applied;
    endproperty
    a_dq_high: assert property (p_dq_high) else $error("repair ran with DQ high");

    property p_early_key;
        q.fsm == S_KEYS && wr && wb_adr_i == `PPR_OFF_KEY && q.tmod < TMOD |=> q.fsm == S_IDLE;
    endproperty
    a_early_key: assert property (p_early_key) else $error("key taken before tMOD");

    property p_four_keys;
        q.fsm == S_IDLE ##1 q.fsm == S_KEYS |-> q.fsm != S_ARMED [*4];
    endproperty
    a_four_keys: assert property (p_four_keys) else $error("armed too soon");

    property p_both_en;
        q.fsm == S_IDLE && wr && wb_adr_i == `PPR_OFF_MODE
            && wb_dat_i[`PPR_BIT_SOFT] && wb_dat_i[`PPR_BIT_HARD] |=> q.fsm == S_IDLE;
    endproperty
    a_both_en: assert property (p_both_en) else $error("entry with both enables");

    property p_hard_entry;
        q.fsm == S_IDLE && wr && wb_adr_i == `PPR_OFF_MODE
            && !wb_dat_i[`PPR_BIT_SOFT] && wb_dat_i[`PPR_BIT_HARD] |=> q.fsm == S_KEYS && q.hard_mode;
    endproperty
    a_hard_entry: assert property (p_hard_entry) else $error("hard entry refused");

    property p_readout;
        rd && wb_adr_i == `PPR_OFF_READOUT
            |=> wb_ack_o && wb_dat_o[7:6] == {CAP_HARD, CAP_SOFT} ##1 !wb_ack_o;
    endproperty
    a_readout: assert property (p_readout) else $error("readout bits wrong");

    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("access not acknowledged");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    property p_target;
        q.fsm == S_ARMED && wr && wb_adr_i == `PPR_OFF_TARGET
            |=> q.fsm == S_DATA && q.row == $past(wb_dat_i[ROWW-1:0])
            && q.tgt == $past(wb_dat_i[`PPR_BANK_LSB +: BKW]);
    endproperty
    a_target: assert property (p_target) else $error("failing row not captured");

    property p_partial_lane;
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i != 4'hF && wb_adr_i == `PPR_OFF_MODE
            |=> $stable({q.soft_en, q.hard_en});
    endproperty
    a_partial_lane: assert property (p_partial_lane) else $error("partial write moved enables");

    property p_mode_off;
        q.fsm != S_IDLE && wr && wb_adr_i == `PPR_OFF_MODE
            && !wb_dat_i[`PPR_BIT_SOFT] && !wb_dat_i[`PPR_BIT_HARD] |=> q.fsm == S_IDLE;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("sequence survived disable");

    property p_wrong_write;
        q.fsm == S_KEYS && wr && wb_adr_i != `PPR_OFF_KEY |=> q.fsm == S_IDLE && q.noop;
    endproperty
    a_wrong_write: assert property (p_wrong_write) else $error("key phase not cut");

    property p_wrong_key;
        q.fsm == S_KEYS && q.keys == 2'h0 && wr && wb_adr_i == `PPR_OFF_KEY
            && wb_dat_i[11:0] != `PPR_KEY0 |=> q.fsm == S_IDLE && q.noop;
    endproperty
    a_wrong_key: assert property (p_wrong_key) else $error("wrong first key taken");

    property p_lookup_hit;
        wr && wb_adr_i == `PPR_OFF_LOOKUP && q.bst[bank_in] != PPR_NONE && q.brow[bank_in] == row_in
            |=> q.lk_hit && q.lk_idx == $past(bank_in);
    endproperty
    a_lookup_hit: assert property (p_lookup_hit) else $error("stored row not redirected");

    c_soft: cover property (burst_wr && !n.bad && !q.hard_mode);
    c_hard_over_soft: cover property (burst_wr && !n.bad && q.hard_mode && q.bst[q.tgt] == PPR_SOFT);
    c_key_noop: cover property (q.fsm == S_KEYS ##1 q.fsm == S_IDLE);
    c_hard_blocked: cover property (burst_wr && !n.bad && q.bst[q.tgt] == PPR_HARD);
    c_early_key: cover property (q.fsm == S_KEYS && wr && wb_adr_i == `PPR_OFF_KEY && q.tmod < TMOD);
endmodule

`default_nettype wire

// file: design/ppr_defs.svh
`ifndef PPR_DEFS_SVH
`define PPR_DEFS_SVH

`define PPR_OFF_MODE 8'h00
`define PPR_OFF_KEY 8'h04
`define PPR_OFF_TARGET 8'h08
`define PPR_OFF_BURST 8'h0C
`define PPR_OFF_STATUS 8'h10
`define PPR_OFF_READOUT 8'h14
`define PPR_OFF_LOOKUP 8'h18
`define PPR_OFF_TABLE 2'h1
`define PPR_BIT_SOFT 5
`define PPR_BIT_HARD 13
`define PPR_BIT_CAP_HARD 7
`define PPR_BIT_CAP_SOFT 6
`define PPR_KEY_GRP_LSB 18
`define PPR_BANK_LSB 20
`define PPR_KEY0 12'hCFF
`define PPR_KEY1 12'h7FF
`define PPR_KEY2 12'hBFF
`define PPR_KEY3 12'h3FF
`define PPR_KEYS_LAST 2'h3
`define PPR_BEATS_LAST 2'h3
`define PPR_TMOD_CYC 24
`define PPR_BANKS 16
`define PPR_ROW_W 18
`define PPR_DQ_W 8

`endif

// file: design/ppr_pkg.sv
package ppr_pkg;
    typedef enum logic [1:0] {PPR_NONE, PPR_SOFT, PPR_HARD} ppr_bank_t;
    typedef enum logic [2:0] {S_IDLE, S_KEYS, S_ARMED, S_DATA, S_DONE} ppr_fsm_t;
endpackage

// file: verification/ppr_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppr_ctl_model #(
    parameter int TMOD = 4
) (
    input wire logic clk_i,
    input wire logic [3:0] lanes_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'hFF;
        wb_sel_o = 4'hF;
        wb_dat_o = 32'h0;
    end

    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rdat);
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= lanes_i;
        wb_dat_o <= dat;
        do @(posedge clk_i); while (wb_ack_i !== 1'b1);
        rdat = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // released lines must not keep looking valid
        wb_adr_o <= ~adr;
        wb_dat_o <= ~dat;
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic repair(input logic [31:0] mode, input logic [3:0] bank, input logic [17:0] row,
                          input logic [7:0] dq, input logic bad_key);
        logic [31:0] r;
        logic [11:0] k [4];
        k = '{12'hCFF, 12'h7FF, 12'hBFF, 12'h3FF};
        xfer(1'b1, 8'h00, 32'h0, r);
        xfer(1'b1, 8'h00, mode, r);
        for (int i = 0; i < 4; i++) begin
            // keys land exactly tMOD apart; needs TMOD of 3 or more
            repeat (TMOD - 3) @(posedge clk_i);
            xfer(1'b1, 8'h04, {20'h0, k[bad_key ? (i ^ 1) : i]}, r);
        end
        xfer(1'b1, 8'h08, {8'h0, bank, 2'b00, row}, r);
        repeat (4) xfer(1'b1, 8'h0C, {8'h0, dq, 8'h0, dq}, r);
        xfer(1'b1, 8'h00, 32'h0, r);
    endtask
endmodule
`default_nettype wire

// file: verification/ppr_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module ppr_top_tb;
    localparam int TMOD = 4;
    localparam logic [31:0] SOFT = 32'h20;
    localparam logic [31:0] HARD = 32'h2000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic por_i = 1'b1;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat, d;
    logic [3:0] lanes = 4'hF;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk_i = ~clk_i;

    ppr_top #(.TMOD_CYC(TMOD)) u_ppr_top (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
    ppr_ctl_model #(.TMOD(TMOD)) u_ppr_ctl_model (.clk_i(clk_i), .lanes_i(lanes), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
        .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat),
        .wb_ack_i(wb_ack));

    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic rd(input logic [7:0] a);
        u_ppr_ctl_model.xfer(1'b0, a, 32'h0, d);
    endtask

    task automatic tbl(input logic [3:0] b, input logic [31:0] e);
        rd(8'h40 + {2'b00, b, 2'b00});
        `CHK(d, e)
    endtask

    task automatic look(input logic [3:0] b, input logic [17:0] row);
        u_ppr_ctl_model.xfer(1'b1, 8'h18, {8'h0, b, 2'b00, row}, d);
        rd(8'h18);
    endtask

    ////////////////////////////////////////////////////////////////
    // hang guard, generous for about ten repair sequences
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge clk_i);
        por_i <= 1'b0;
        rst_i <= 1'b0;
        rd(8'h14);
        `CHK(d, 32'h0000_00C0)
        rd(8'h10);
        `CHK(d[7:4], 4'h4)
        tbl(4'h3, 32'h0);
        u_ppr_ctl_model.repair(SOFT, 4'h3, 18'h00123, 8'h00, 1'b0);
        tbl(4'h3, 32'h1000_0123);
        look(4'h3, 18'h00123);
        `CHK(d, 32'h0000_0031)
        u_ppr_ctl_model.repair(SOFT, 4'h3, 18'h00456, 8'h00, 1'b0);
        tbl(4'h3, 32'h1000_0456);
        look(4'h3, 18'h00123);
        `CHK(d[0], 1'b0)
        u_ppr_ctl_model.repair(SOFT, 4'h5, 18'h00077, 8'h00, 1'b0);
        u_ppr_ctl_model.repair(HARD, 4'h3, 18'h2AAAA, 8'h00, 1'b0);
        tbl(4'h3, 32'h2002_AAAA);
        tbl(4'h5, 32'h1000_0077);
        look(4'h3, 18'h2AAAA);
        `CHK(d, 32'h0000_0033)
        u_ppr_ctl_model.repair(SOFT, 4'h3, 18'h00001, 8'h00, 1'b0);
        u_ppr_ctl_model.repair(HARD, 4'h3, 18'h00002, 8'h00, 1'b0);
        tbl(4'h3, 32'h2002_AAAA);
        u_ppr_ctl_model.repair(SOFT, 4'h7, 18'h00011, 8'h01, 1'b0);
        tbl(4'h7, 32'h0);
        u_ppr_ctl_model.repair(SOFT, 4'h8, 18'h00005, 8'h00, 1'b1);
        tbl(4'h8, 32'h0);
        u_ppr_ctl_model.repair(SOFT | HARD, 4'h9, 18'h00009, 8'h00, 1'b0);
        tbl(4'h9, 32'h0);
        u_ppr_ctl_model.repair(32'h0, 4'h9, 18'h00009, 8'h00, 1'b0);
        tbl(4'h9, 32'h0);
        // a write on two byte lanes only must leave the enables alone
        lanes <= 4'h3;
        u_ppr_ctl_model.xfer(1'b1, 8'h00, SOFT, d);
        lanes <= 4'hF;
        rd(8'h00);
        `CHK(d, 32'h0)
        // second key lands before tMOD and ends the phase, then a target write cuts a new hard key phase
        u_ppr_ctl_model.xfer(1'b1, 8'h00, SOFT, d);
        u_ppr_ctl_model.xfer(1'b1, 8'h04, 32'h0000_0CFF, d);
        u_ppr_ctl_model.xfer(1'b1, 8'h04, 32'h0000_07FF, d);
        rd(8'h10);
        `CHK(d, 32'h0000_0044)
        rd(8'h00);
        `CHK(d, SOFT)
        u_ppr_ctl_model.xfer(1'b1, 8'h00, 32'h0, d);
        u_ppr_ctl_model.xfer(1'b1, 8'h00, HARD, d);
        u_ppr_ctl_model.xfer(1'b1, 8'h08, 32'h0030_0001, d);
        rd(8'h10);
        `CHK(d, 32'h0000_0044)
        // device reset drops soft entries only
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        tbl(4'h3, 32'h2002_AAAA);
        tbl(4'h5, 32'h0);
        rd(8'h3C);
        `CHK(d, 32'h0)
        print_verdict();
    end
endmodule
`default_nettype wire
